// [hdl/pixel_front_pkg.sv]
// Constants, register map and types for the pixel format front end
package pixel_front_pkg;

  // Register byte addresses on the AHB-Lite slave
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_PATTERN = 8'h04;
  localparam logic [7:0] OFS_GEOM    = 8'h08;
  localparam logic [7:0] OFS_MAXSIZE = 8'h0C;
  localparam logic [7:0] OFS_STATUS  = 8'h10;

  // Control register fields
  localparam int CTRL_ACQ_BIT   = 0;
  localparam int CTRL_ADC_LSB   = 1;
  localparam int CTRL_OUTW_LSB  = 4;
  localparam int CTRL_REVX_BIT  = 8;
  localparam int CTRL_REVY_BIT  = 9;

  // Pattern register fields
  localparam int PAT_SEL_BIT    = 0;
  localparam int PAT_TYPE_LSB   = 4;

  // Geometry register fields, each factor three bits wide
  localparam int GEOM_HBIN_LSB  = 0;
  localparam int GEOM_VBIN_LSB  = 4;
  localparam int GEOM_HSKIP_LSB = 8;
  localparam int GEOM_VSKIP_LSB = 12;

  // Reset values
  localparam logic [1:0] ADC_RESET    = 2'h1;
  localparam logic [2:0] OUTW_RESET   = 3'h4;
  localparam logic [2:0] FACTOR_RESET = 3'h1;

  // Digitizer depth codes
  localparam logic [1:0] ADC_10 = 2'h0;
  localparam logic [1:0] ADC_12 = 2'h1;
  localparam logic [1:0] ADC_14 = 2'h2;

  // Output pixel width codes: 8, 10, 12, 14, 16 bits
  localparam logic [2:0] OUTW_8  = 3'h0;
  localparam logic [2:0] OUTW_10 = 3'h1;
  localparam logic [2:0] OUTW_12 = 3'h2;
  localparam logic [2:0] OUTW_14 = 3'h3;
  localparam logic [2:0] OUTW_16 = 3'h4;

  // Pattern source selector and pattern types
  localparam logic       SRC_SENSOR   = 1'b0;
  localparam logic       SRC_PIPELINE = 1'b1;
  localparam logic [1:0] PAT_OFF      = 2'h0;
  localparam logic [1:0] PAT_SENSOR   = 2'h1;
  localparam logic [1:0] PAT_INCR     = 2'h1;
  localparam logic [1:0] PAT_FRAMESEQ = 2'h2;

  // Sensor array size defaults
  localparam int SENSOR_W_DEF = 1936;
  localparam int SENSOR_H_DEF = 1464;

  // Readout sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_READ = 3'b010,
    S_EMIT = 3'b100
  } seq_state_t;

endpackage

// [hdl/pixel_format_front_end.sv]
// Pixel format front end: readout sequencing, patterns, mirroring, AHB-Lite registers
// Functional notes
// - Narrower output width drops low sample bits
// - Wider output width pads low bits
// - Samples sit MSB-aligned in 16-bit words
// - Twelve-bit sample fills bits 15..4
// - Ten, twelve, fourteen bit depths supported
// - Two pattern sources picked by selector
// - Type off disables selected source
// - Sensor source offers one sensor pattern
// - Pipeline source: increment or frame sequence
// - Increment pattern counts 0..255 then wraps
// - Frame sequence varies, restarts per acquisition
// - Pipeline pattern overrides sensor pattern
// - Patterns ignore exposure, gain, offset
// - Real data only with both sources off
// - Reverse X flips lines, swaps column phase
// - Reverse Y flips frame, swaps row phase
// - Binning factor combines cells, one disables
// - Max size reported after binning only
// - Decimation keeps one pixel per window
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module pixel_format_front_end
  import pixel_front_pkg::*;
#(
  parameter int SENSOR_W = SENSOR_W_DEF,
  parameter int SENSOR_H = SENSOR_H_DEF
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             cellReq,
  output logic      [10:0] cellX,
  output logic      [10:0] cellY,
  input  wire logic        cellValid,
  input  wire logic [13:0] cellSample,
  output logic             sensorTestEnable,
  output logic             pixValid,
  input  wire logic        pixReady,
  output logic      [15:0] pixData,
  output logic             pixFrameStart,
  output logic             pixLineEnd,
  output logic      [1:0]  mosaicPhase
);

  localparam logic [10:0] LAST_X = 11'(SENSOR_W - 1);
  localparam logic [10:0] LAST_Y = 11'(SENSOR_H - 1);
  localparam logic [10:0] FULL_W = 11'(SENSOR_W);
  localparam logic [10:0] FULL_H = 11'(SENSOR_H);

  // Factor to shift: 2 and 4 are honoured, anything else acts as 1
  function automatic logic [1:0] factorShift(input logic [2:0] f);
    factorShift = (f == 3'h2) ? 2'h1 : ((f == 3'h4) ? 2'h2 : 2'h0);
  endfunction

  // Register state
  logic        acqEnable_q;
  logic [1:0]  adcSel_q;
  logic [2:0]  outWidth_q;
  logic        revX_q;
  logic        revY_q;
  logic        patSel_q;
  logic [1:0]  sensorPatType_q;
  logic [1:0]  pipePatType_q;
  logic [2:0]  hBin_q;
  logic [2:0]  vBin_q;
  logic [2:0]  hSkip_q;
  logic [2:0]  vSkip_q;
  logic [7:0]  busAddr_q;
  logic        wrPend_q;
  logic        rdWait_q;
  logic [31:0] rdData_q;

  // Sequencer state
  seq_state_t  state_q;
  logic [10:0] outX_q;
  logic [10:0] outY_q;
  logic [1:0]  subX_q;
  logic [1:0]  subY_q;
  logic [19:0] acc_q;
  logic [7:0]  incCount_q;
  logic [7:0]  frameIdx_q;
  logic        acqPrev_q;
  logic [15:0] pixData_q;

  // AHB-Lite address phase decode; reads take one wait state
  wire addrPhase = hsel && hready && htrans[1];
  wire wrEn      = wrPend_q;
  wire wrCtrl    = wrEn && (busAddr_q == OFS_CTRL);
  wire wrPat     = wrEn && (busAddr_q == OFS_PATTERN);
  wire wrGeom    = wrEn && (busAddr_q == OFS_GEOM);
  assign hreadyout = !rdWait_q;
  assign hresp     = 1'b0;
  assign hrdata    = rdData_q;

  // Effective geometry: decimation is suppressed whenever binning is on
  wire [1:0]  binShX  = factorShift(hBin_q);
  wire [1:0]  binShY  = factorShift(vBin_q);
  wire        binning = (hBin_q != 3'h1) || (vBin_q != 3'h1);
  wire [1:0]  skShX   = binning ? 2'h0 : factorShift(hSkip_q);
  wire [1:0]  skShY   = binning ? 2'h0 : factorShift(vSkip_q);
  wire [2:0]  stepShX = {1'b0, binShX} + {1'b0, skShX};
  wire [2:0]  stepShY = {1'b0, binShY} + {1'b0, skShY};
  wire [10:0] maxW    = FULL_W >> binShX;
  wire [10:0] maxH    = FULL_H >> binShY;
  wire [10:0] outLastX = (FULL_W >> stepShX) - 11'h1;
  wire [10:0] outLastY = (FULL_H >> stepShY) - 11'h1;

  // Pattern source enables; pipeline wins when both are on
  wire sensorOn = (sensorPatType_q == PAT_SENSOR);
  wire pipeOn   = (pipePatType_q != PAT_OFF);
  assign sensorTestEnable = sensorOn && !pipeOn;

  // Readout address with mirroring before any cropping downstream
  wire [10:0] baseX = outX_q << stepShX;
  wire [10:0] baseY = outY_q << stepShY;
  wire [10:0] offX  = baseX + {9'h0, subX_q};
  wire [10:0] offY  = baseY + {9'h0, subY_q};
  assign cellX = revX_q ? (LAST_X - offX) : offX;
  assign cellY = revY_q ? (LAST_Y - offY) : offY;
  assign mosaicPhase = {revY_q, revX_q};

  // Left alignment of the digitizer sample into 16 bits
  logic [15:0] alignWord;
  always_comb begin
    case (adcSel_q)
      ADC_10:  alignWord = {cellSample[9:0], 6'h00};
      ADC_12:  alignWord = {cellSample[11:0], 4'h0};
      default: alignWord = {cellSample[13:0], 2'h0};
    endcase
  end

  // Output width mask: drops low bits or pads them with zero
  logic [15:0] widthMask;
  always_comb begin
    case (outWidth_q)
      OUTW_8:  widthMask = 16'hFF00;
      OUTW_10: widthMask = 16'hFFC0;
      OUTW_12: widthMask = 16'hFFF0;
      OUTW_14: widthMask = 16'hFFFC;
      default: widthMask = 16'hFFFF;
    endcase
  end

  // Binning sum, average and final formatting
  wire         cellTake = cellReq && cellValid;
  wire         cellDone = pipeOn || cellTake;
  wire [19:0]  accNext  = acc_q + (pipeOn ? 20'h0 : {4'h0, alignWord});
  wire [2:0]   binShTot = {1'b0, binShX} + {1'b0, binShY};
  wire [19:0]  avgWide  = accNext >> binShTot;
  wire [15:0]  padMask  = 16'hFFFF << {~adcSel_q[1], ~adcSel_q[0] | adcSel_q[1], 1'b0};
  wire [15:0]  fmtWord  = avgWide[15:0] & widthMask & padMask;
  wire [7:0]   seqValue = outX_q[7:0] + outY_q[7:0] + frameIdx_q;
  wire [7:0]   patValue = (pipePatType_q == PAT_INCR) ? incCount_q : seqValue;
  wire [15:0]  patWord  = {patValue, 8'h00} & widthMask;
  wire         lastSubX = (subX_q == 2'((3'h1 << binShX) - 3'h1));
  wire         lastSubY = (subY_q == 2'((3'h1 << binShY) - 3'h1));
  wire         lastSub  = lastSubX && lastSubY;
  wire         lastX    = (outX_q == outLastX);
  wire         lastY    = (outY_q == outLastY);
  wire         pixTake  = pixValid && pixReady;

  // Stream handshake outputs
  assign cellReq       = (state_q == S_READ) && !pipeOn;
  assign pixValid      = (state_q == S_EMIT);
  assign pixData       = pixData_q;
  assign pixFrameStart = pixValid && (outX_q == 11'h0) && (outY_q == 11'h0);
  assign pixLineEnd    = pixValid && lastX;

  // Bus slave: address capture, write apply, read data staging
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busAddr_q <= 8'h00;
      wrPend_q  <= 1'b0;
      rdWait_q  <= 1'b0;
      rdData_q  <= 32'h0000_0000;
    end else begin
      wrPend_q <= addrPhase && hwrite;
      rdWait_q <= addrPhase && !hwrite;
      if (addrPhase) begin
        busAddr_q <= {haddr[7:2], 2'h0};
      end
      if (rdWait_q) begin
        case (busAddr_q)
          OFS_CTRL:    rdData_q <= {22'h0, revY_q, revX_q, 1'b0, outWidth_q, 1'b0,
                                    adcSel_q, acqEnable_q};
          OFS_PATTERN: rdData_q <= {26'h0, (patSel_q ? pipePatType_q : sensorPatType_q),
                                    3'h0, patSel_q};
          OFS_GEOM:    rdData_q <= {17'h0, vSkip_q, 1'b0, hSkip_q, 1'b0, vBin_q, 1'b0,
                                    hBin_q};
          OFS_MAXSIZE: rdData_q <= {5'h0, maxH, 5'h0, maxW};
          OFS_STATUS:  rdData_q <= {frameIdx_q, 13'h0, pipeOn, sensorOn, binning,
                                    mosaicPhase, 3'h0, state_q};
          default:     rdData_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control registers written from the data phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acqEnable_q <= 1'b0;
      adcSel_q    <= ADC_RESET;
      outWidth_q  <= OUTW_RESET;
      revX_q      <= 1'b0;
      revY_q      <= 1'b0;
    end else if (wrCtrl) begin
      acqEnable_q <= hwdata[CTRL_ACQ_BIT];
      adcSel_q    <= hwdata[CTRL_ADC_LSB +: 2];
      outWidth_q  <= hwdata[CTRL_OUTW_LSB +: 3];
      revX_q      <= hwdata[CTRL_REVX_BIT];
      revY_q      <= hwdata[CTRL_REVY_BIT];
    end
  end

  // Pattern type writes go to whichever source the selector names
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      patSel_q        <= SRC_SENSOR;
      sensorPatType_q <= PAT_OFF;
      pipePatType_q   <= PAT_OFF;
    end else if (wrPat) begin
      patSel_q <= hwdata[PAT_SEL_BIT];
      if (hwdata[PAT_SEL_BIT] == SRC_PIPELINE) begin
        pipePatType_q <= hwdata[PAT_TYPE_LSB +: 2];
      end else begin
        sensorPatType_q <= hwdata[PAT_TYPE_LSB +: 2];
      end
    end
  end

  // Binning and decimation factors
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hBin_q  <= FACTOR_RESET;
      vBin_q  <= FACTOR_RESET;
      hSkip_q <= FACTOR_RESET;
      vSkip_q <= FACTOR_RESET;
    end else if (wrGeom) begin
      hBin_q  <= hwdata[GEOM_HBIN_LSB +: 3];
      vBin_q  <= hwdata[GEOM_VBIN_LSB +: 3];
      hSkip_q <= hwdata[GEOM_HSKIP_LSB +: 3];
      vSkip_q <= hwdata[GEOM_VSKIP_LSB +: 3];
    end
  end

  // Frame index restarts whenever acquisition is started
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acqPrev_q  <= 1'b0;
      frameIdx_q <= 8'h00;
    end else begin
      acqPrev_q <= acqEnable_q;
      if (acqEnable_q && !acqPrev_q) begin
        frameIdx_q <= 8'h00;
      end else if (pixTake && lastX && lastY) begin
        frameIdx_q <= frameIdx_q + 8'h01;
      end
    end
  end

  // Readout sequencer: read window cells, then present one pixel
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= S_IDLE;
      outX_q     <= 11'h000;
      outY_q     <= 11'h000;
      subX_q     <= 2'h0;
      subY_q     <= 2'h0;
      acc_q      <= 20'h00000;
      incCount_q <= 8'h00;
      pixData_q  <= 16'h0000;
    end else begin
      case (state_q)
        S_IDLE: begin
          outX_q     <= 11'h000;
          outY_q     <= 11'h000;
          subX_q     <= 2'h0;
          subY_q     <= 2'h0;
          acc_q      <= 20'h00000;
          incCount_q <= 8'h00;
          if (acqEnable_q) begin
            state_q <= S_READ;
          end
        end
        S_READ: begin
          if (cellDone) begin
            if (lastSub) begin
              acc_q     <= 20'h00000;
              subX_q    <= 2'h0;
              subY_q    <= 2'h0;
              pixData_q <= pipeOn ? patWord : fmtWord;
              state_q   <= S_EMIT;
            end else begin
              acc_q <= accNext;
              if (lastSubX) begin
                subX_q <= 2'h0;
                subY_q <= subY_q + 2'h1;
              end else begin
                subX_q <= subX_q + 2'h1;
              end
            end
          end
        end
        S_EMIT: begin
          if (pixReady) begin
            incCount_q <= incCount_q + 8'h01;
            if (lastX) begin
              outX_q <= 11'h000;
              if (lastY) begin
                outY_q     <= 11'h000;
                incCount_q <= 8'h00;
                state_q    <= acqEnable_q ? S_READ : S_IDLE;
              end else begin
                outY_q  <= outY_q + 11'h001;
                state_q <= S_READ;
              end
            end else begin
              outX_q  <= outX_q + 11'h001;
              state_q <= S_READ;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Checks on formatting, pattern selection, geometry and bus timing
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_pad_zero;
    (pixValid && !pipeOn) |-> ((pixData & ~(widthMask & padMask)) == 16'h0000);
  endproperty
  a_pad_zero: assert property (p_pad_zero) else $error("padding bits not zero");

  property p_twelve_bit;
    (adcSel_q == ADC_12) |-> (alignWord == {cellSample[11:0], 4'h0});
  endproperty
  a_twelve_bit: assert property (p_twelve_bit) else $error("12-bit alignment wrong");

  property p_truncate;
    (outWidth_q == OUTW_8) |-> (fmtWord[15:8] == avgWide[15:8]) && (fmtWord[7:0] == 8'h00);
  endproperty
  a_truncate: assert property (p_truncate) else $error("8-bit truncation wrong");

  property p_pipe_no_read;
    pipeOn |-> !cellReq && !sensorTestEnable;
  endproperty
  a_pipe_no_read: assert property (p_pipe_no_read) else $error("pipeline pattern lost");

  property p_real_data;
    (state_q == S_READ && cellDone && lastSub && !pipeOn) |=> (pixData == $past(fmtWord));
  endproperty
  a_real_data: assert property (p_real_data) else $error("sensor pixel not passed");

  property p_no_skip_binning;
    binning |-> (stepShX == {1'b0, binShX}) && (stepShY == {1'b0, binShY});
  endproperty
  a_no_skip_binning: assert property (p_no_skip_binning) else $error("skip with binning");

  property p_max_width;
    (hBin_q == 3'h2) |-> (maxW == (FULL_W >> 1));
  endproperty
  a_max_width: assert property (p_max_width) else $error("max width wrong");

  property p_mirror_x;
    (cellReq && revX_q && outX_q == 11'h000 && subX_q == 2'h0) |-> (cellX == LAST_X);
  endproperty
  a_mirror_x: assert property (p_mirror_x) else $error("reverse X address wrong");

  property p_frame_restart;
    (acqEnable_q && !acqPrev_q) |=> (frameIdx_q == 8'h00);
  endproperty
  a_frame_restart: assert property (p_frame_restart) else $error("sequence not reset");

  sequence s_inc_emit;
    pixTake && (pipePatType_q == PAT_INCR) && !lastX;
  endsequence
  property p_incr_step;
    s_inc_emit |=> (incCount_q == $past(pixData[15:8] & widthMask[15:8]) + 8'h01);
  endproperty
  a_incr_step: assert property (p_incr_step) else $error("increment step wrong");

  property p_read_wait;
    (addrPhase && !hwrite) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

endmodule
`default_nettype wire

// [verif/sensor_digitizer_model.sv]
// Behavioural digitizer that answers cell read requests from the front end
`timescale 1ns/100ps
`default_nettype none
module sensor_digitizer_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        cellReq,
  input  wire logic [10:0] cellX,
  input  wire logic [10:0] cellY,
  input  wire logic        sensorTestEnable,
  output logic             cellValid,
  output logic      [13:0] cellSample
);
  int seed = 86082;
  int waitCnt;

  // Answer after a random wait of 0 to 2 cycles; between answers the data lines toggle
  // so that no stale sample can pass for a fresh one
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cellValid <= 1'b0;
      cellSample <= 14'h0000;
      waitCnt <= 0;
    end else if (cellReq && !cellValid && waitCnt == 0) begin
      cellValid <= 1'b1;
      cellSample <= sensorTestEnable ? (14'h3C00 | 14'(cellX))
                                     : ({cellX[6:0], cellY[6:0]} ^ 14'h1A5B);
    end else begin
      if (cellReq && !cellValid) begin
        waitCnt <= waitCnt - 1;
      end else begin
        waitCnt <= $unsigned($random(seed)) % 3;
      end
      cellValid <= 1'b0;
      cellSample <= ~cellSample;
    end
  end
endmodule
`default_nettype wire

// [verif/test_pixel_format_front_end.sv]
// Self-checking bench for the pixel format front end
`timescale 1ns/100ps
`default_nettype none
module test_pixel_format_front_end
  import pixel_front_pkg::*;
();
  localparam int W = 16;
  localparam int H = 18;
  typedef struct {int d, w, rx, ry, hb, vb, hs, vs, sens, pipe, nf;} cfg_t;
  logic        clock, rst_n, hsel, hwrite, hreadyout, hresp, pixReady;
  logic [7:0]  haddr;
  logic [1:0]  htrans, mosaicPhase;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, r;
  logic        cellReq, cellValid, sensorTestEnable, pixValid, pixFrameStart, pixLineEnd;
  logic [10:0] cellX, cellY;
  logic [13:0] cellSample;
  logic [15:0] pixData;
  logic [17:0] expQ[$];
  int          errors, check_count, frameCount;
  int          seed = 86082;
  int          wt[5] = '{8, 10, 12, 14, 16};
  cfg_t        c;

  pixel_format_front_end #(.SENSOR_W(W), .SENSOR_H(H)) DUT (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cellReq(cellReq),
    .cellX(cellX), .cellY(cellY), .cellValid(cellValid), .cellSample(cellSample),
    .sensorTestEnable(sensorTestEnable), .pixValid(pixValid), .pixReady(pixReady),
    .pixData(pixData), .pixFrameStart(pixFrameStart), .pixLineEnd(pixLineEnd),
    .mosaicPhase(mosaicPhase));

  sensor_digitizer_model sensor (
    .clock(clock), .rst_n(rst_n), .cellReq(cellReq), .cellX(cellX), .cellY(cellY),
    .sensorTestEnable(sensorTestEnable), .cellValid(cellValid), .cellSample(cellSample));

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Bounded wait for the slave to raise hreadyout at a rising edge
  task automatic waitReady();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      errors++;
      end_of_test();
    end
  endtask

  // One AHB-Lite single word transfer: address phase, then data phase
  task automatic ahb(logic wr, logic [7:0] a, logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady();
    rd = hrdata;
  endtask

  task automatic rdchk(string name, logic [7:0] a, logic [31:0] exp);
    ahb(1'b0, a, 32'h0, r);
    check(name, r, exp);
  endtask

  function automatic logic [31:0] ctrlWord(int acq);
    return 32'(c.ry << 9 | c.rx << 8 | (c.w - 8) / 2 << 4 | (c.d - 10) / 2 << 1 | acq);
  endfunction

  // Sample as the model sends it, mirrored, then left-aligned in the 16-bit word
  function automatic logic [15:0] cellWord(int x, int y);
    logic [13:0] s;
    int          cx, cy;
    cx = c.rx ? W - 1 - x : x;
    cy = c.ry ? H - 1 - y : y;
    s = c.sens ? (14'h3C00 | 14'(cx)) : ({7'(cx), 7'(cy)} ^ 14'h1A5B);
    return 16'(s & ((1 << c.d) - 1)) << (16 - c.d);
  endfunction

  function automatic logic [15:0] pixWord(int ox, int oy, int fi, int n);
    int          sum;
    logic [15:0] v;
    sum = 0;
    for (int i = 0; i < c.hb * c.vb; i++) begin
      sum += cellWord(ox * c.hb * c.hs + i % c.hb, oy * c.vb * c.vs + i / c.hb);
    end
    v = c.pipe == 1 ? {8'(n), 8'h00} : c.pipe > 1 ? {8'(ox + oy + fi), 8'h00}
                                                  : 16'(sum / (c.hb * c.vb));
    return v & (16'hFFFF << (16 - c.w)) & (16'hFFFF << (16 - c.d));
  endfunction

  // Configure with acquisition off, note every expected pixel, then run nf frames
  task automatic run(cfg_t k);
    int n, ow, oh;
    c = k;
    ahb(1'b1, OFS_CTRL, ctrlWord(0), r);
    ahb(1'b1, OFS_PATTERN, {26'h0, 2'(c.sens), 4'h0}, r);
    ahb(1'b1, OFS_PATTERN, {26'h0, 2'(c.pipe), 4'h1}, r);
    ahb(1'b0, OFS_PATTERN, 32'h0, r);
    check("pattern type", r & 32'h30, 32'(c.pipe << 4));
    ahb(1'b1, OFS_GEOM, 32'(c.hb | c.vb << 4 | c.hs << 8 | c.vs << 12), r);
    rdchk("max size", OFS_MAXSIZE, 32'((H / c.vb) << 16 | W / c.hb));
    if (c.hb * c.vb != 1) begin
      c.hs = 1;
      c.vs = 1;
    end
    ow = W / (c.hb * c.hs);
    oh = H / (c.vb * c.vs);
    for (int f = 0; f < c.nf; f++) begin
      for (int y = 0; y < oh; y++) begin
        for (int x = 0; x < ow; x++) begin
          expQ.push_back({x == 0 && y == 0, x == ow - 1, pixWord(x, y, f, y * ow + x)});
        end
      end
    end
    frameCount = 0;
    ahb(1'b1, OFS_CTRL, ctrlWord(1), r);
    check("test enable", sensorTestEnable, c.sens != 0 && c.pipe == 0);
    check("mosaic", mosaicPhase, {c.ry[0], c.rx[0]});
    for (n = 0; n < 30000 && frameCount < c.nf; n++) @(posedge clock);
    ahb(1'b1, OFS_CTRL, ctrlWord(0), r);
    for (n = 0; n < 30000 && expQ.size() > 0; n++) @(posedge clock);
    repeat (20) @(posedge clock);
    ahb(1'b0, OFS_STATUS, 32'h0, r);
    check("idle state", r & 32'h7, 32'h1);
    $display("Test done: depth %0d width %0d frames %0d", c.d, c.w, c.nf);
    if (expQ.size() > 0) begin
      errors++;
      end_of_test();
    end
  endtask

  // Every accepted pixel is compared with the oldest note
  always @(posedge clock) begin
    if (rst_n === 1'b1 && pixValid === 1'b1 && pixReady === 1'b1) begin
      if (pixFrameStart === 1'b1) frameCount++;
      if (expQ.size() == 0) begin
        check("extra pixel", 32'h1, 32'h0);
      end else begin
        check("pixel", {pixFrameStart, pixLineEnd, pixData}, expQ.pop_front());
      end
    end
  end

  // Downstream stalls at random so held outputs are exercised
  always @(posedge clock) begin
    pixReady <= ($random(seed) & 3) != 0;
  end

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Reset, register checks, then the frame scenarios
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pixReady = 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    check("hresp", hresp, 32'h0);
    rdchk("ctrl", OFS_CTRL, 32'(ADC_RESET) << CTRL_ADC_LSB | 32'(OUTW_RESET) << CTRL_OUTW_LSB);
    rdchk("pattern", OFS_PATTERN, 32'h0);
    rdchk("geom", OFS_GEOM, 32'h0000_1111);
    ahb(1'b1, OFS_MAXSIZE, 32'hFFFF_FFFF, r);
    rdchk("max size ro", OFS_MAXSIZE, 32'h0012_0010);
    rdchk("unmapped", 8'h14, 32'h0);
    for (int i = 0; i < 15; i++) begin
      run('{10 + 2 * (i % 3), wt[i / 3], 0, 0, 1, 1, 1, 1, 0, 0, 1});
    end
    run('{14, 16, 1, 0, 1, 1, 1, 1, 0, 0, 1});
    run('{12, 16, 0, 1, 1, 1, 1, 1, 0, 0, 1});
    run('{10, 16, 1, 1, 1, 1, 1, 1, 0, 0, 1});
    run('{12, 16, 0, 0, 2, 2, 1, 1, 0, 0, 1});
    run('{14, 12, 1, 0, 4, 1, 1, 1, 0, 0, 1});
    run('{12, 16, 0, 0, 1, 1, 2, 2, 0, 0, 1});
    run('{12, 16, 0, 0, 2, 1, 2, 2, 0, 0, 1});
    // Pattern runs, then one run with both sources off; no exposure or gain loops act in this block
    run('{12, 16, 0, 0, 1, 1, 1, 1, 1, 0, 1});
    run('{12, 12, 0, 0, 1, 1, 1, 1, 0, 1, 1});
    run('{12, 16, 0, 0, 1, 1, 1, 1, 0, 2, 2});
    run('{12, 16, 0, 0, 1, 1, 1, 1, 0, 3, 2});
    run('{12, 16, 0, 0, 1, 1, 1, 1, 1, 1, 1});
    run('{12, 16, 0, 0, 1, 1, 1, 1, 0, 0, 1});
    end_of_test();
  end
endmodule
`default_nettype wire
